/* lhi_pkg.sv */
/*
 lhi_pkg: constants, types and the operation list of the host port.
 assumes: one 25 MHz clock, synchronous active-low reset.
*/
// Operation
// RULE1 - offer 68-style, 80-style (18/16/9/8 bits) and serial buses, chosen by pins
// RULE2 - hold 18-bit index pointer, write staging and read staging registers
// RULE3 - memory writes land in write staging, then move to memory automatically
// RULE4 - first memory word read is a dummy; later words are valid
// RULE5 - logic operations use the stored word fetched through read staging
// RULE6 - instructions other than oscillation start take no clock cycles
// RULE7 - select low: index write or status read; high: data through staging
// RULE8 - 68 uses direction plus enable; 80 uses separate write and read strobes
// RULE9 - serial direction and select bits choose index, status, write or read
// RULE10 - chip select and valid flag decide memory write and address advance; valid flag gates only the write, every captured pixel steps the address
// RULE11 - rgb mode captures pixel bus on enable, valid and sync inputs
// RULE12 - vsync mode runs on internal clock, only frame start follows vsync
// RULE13 - bit write mask, logic operations and conditional writes on memory
// RULE14 - address-set instruction loads the address counter
// RULE15 - address counter steps by one after writes, direction from two-bit field
// RULE16 - memory read leaves the address counter unchanged
// RULE17 - writes are confined to the window rectangle
// RULE18 - memory holds 18 bits per pixel, 132 by 176
// RULE19 - refresh reads and host access never share a cycle; only queued writes skip refresh cycles, host memory reads are not held off
// RULE20 - polarity, frame start, line clock, equalize and gate-off monitor outputs
// RULE21 - oscillator stops in standby; restart takes a start-up delay
// RULE22 - source data latched per full line; shift bit reverses the order
// RULE23 - shift bit zero: address zero drives first source; one: the last
// RULE24 - equalize output low in normal display, high while equalizing
// RULE25 - reset clears index, staging, address counter and dummy-read state
package lhi_pkg;
	localparam int DW          = 18;
	localparam int COLS        = 132;
	localparam int ROWS        = 176;
	localparam int WORDS       = COLS * ROWS;
	localparam int NSRC        = 396;
	localparam int FIFO_DEPTH  = 16;
	localparam int CLK_KHZ     = 25000;
	localparam int OSC_START_US = 10;
	localparam int OSC_START_CLKS = OSC_START_US * CLK_KHZ / 1000;
	localparam int DOT_DIV     = 4;
	localparam int LINE_DOTS   = 160;
	localparam int FRAME_LINES = 180;
	localparam int EQ_DOTS     = 4;
	localparam int LCLK_DOTS   = 2;
	localparam int SPI_HEAD    = 8;
	// interface mode pins: [3:2] bus kind, [1:0] width
	localparam logic [1:0] IM_68  = 2'h0;
	localparam logic [1:0] IM_80  = 2'h1;
	localparam logic [1:0] IM_SPI = 2'h2;
	localparam logic [1:0] BW_18  = 2'h0;
	localparam logic [1:0] BW_16  = 2'h1;
	localparam logic [1:0] BW_9   = 2'h2;
	// index values
	localparam logic [7:0] IX_DISP  = 8'h07;
	localparam logic [7:0] IX_ENTRY = 8'h03;
	localparam logic [7:0] IX_ADDR  = 8'h21;
	localparam logic [7:0] IX_GRAPHICS_MEMORY  = 8'h22;
	localparam logic [7:0] IX_MASK  = 8'h23;
	localparam logic [7:0] IX_LOGIC = 8'h24;
	localparam logic [7:0] IX_CMP   = 8'h25;
	localparam logic [7:0] IX_WINH  = 8'h44;
	localparam logic [7:0] IX_WINV  = 8'h45;
	// field positions
	localparam int DSP_ON   = 0;
	localparam int DSP_SS   = 1;
	localparam int DSP_RGB  = 2;
	localparam int DSP_VSY  = 3;
	localparam int DSP_STBY = 4;
	localparam int ENT_ID   = 4;
	localparam int LOG_CND  = 2;
	// values after reset
	localparam logic [15:0] RST_ENTRY = 16'h0030;
	localparam logic [15:0] RST_WINH  = 16'h8300;
	localparam logic [15:0] RST_WINV  = 16'hAF00;
	localparam logic [4:0]  RST_DISP  = 5'h01;
	typedef enum logic [1:0] {OP_SET, OP_OR, OP_AND, OP_XOR} lhi_op_t;
	typedef enum {SP_IDLE, SP_HEAD, SP_DATA} lhi_spi_t;
	typedef struct packed {
		logic          wr;
		logic [DW-1:0] data;
	} lhi_ent_t;
	typedef struct packed {
		logic          wr;
		logic          rd;
		logic          rs;
		logic [DW-1:0] data;
	} lhi_tx_t;
endpackage : lhi_pkg

/* lhi_sync.sv */
/*
 lhi_sync: two-flop synchroniser for a vector of pin inputs.
 assumes: inputs are asynchronous to clk; RV gives the idle level per bit.
*/
module lhi_sync #(
	parameter int         W  = 1,
	parameter logic [W-1:0] RV = '0
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// data
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] m_q;
	logic [W-1:0] s_q;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			m_q <= RV;
			s_q <= RV;
		end else begin
			m_q <= d;
			s_q <= m_q;
		end
	end

	assign q = s_q;
endmodule : lhi_sync

/* lhi_fifo.sv */
/*
 lhi_fifo: flip-flop FIFO with valid/ready on both sides.
 assumes: DEPTH is a power of two; one clock.
*/
module lhi_fifo #(
	parameter int W     = 19,
	parameter int DEPTH = 16
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic      [W-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_q [DEPTH];
	logic [AW:0]  wp_q;
	logic [AW:0]  rp_q;

	assign in_ready  = !((wp_q[AW] != rp_q[AW]) && (wp_q[AW-1:0] == rp_q[AW-1:0]));
	assign out_valid = (wp_q != rp_q);
	assign out_data  = mem_q[rp_q[AW-1:0]];

	always_ff @(posedge clk) begin
		if (in_valid && in_ready) begin
			mem_q[wp_q[AW-1:0]] <= in_data;
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			wp_q <= '0;
			rp_q <= '0;
		end else begin
			if (in_valid && in_ready) begin
				wp_q <= wp_q + 1'b1;
			end
			if (out_valid && out_ready) begin
				rp_q <= rp_q + 1'b1;
			end
		end
	end
endmodule : lhi_fifo

/* lhi_host_port.sv */
/*
 lhi_host_port: bus decode, staging registers, memory engine, timing and source latch.
 assumes: all pins asynchronous; clk is the oscillator or external clock.
*/
module lhi_host_port (
	// clock and reset
	input  wire logic          clk,
	input  wire logic          rst_b,
	// mode straps
	input  wire logic [3:0]    interface_mode_pins,
	// parallel bus
	input  wire logic          chip_select_n,
	input  wire logic          register_select_line,
	input  wire logic          rw_wr_n,
	input  wire logic          e_rd_n,
	input  wire logic [17:0]   db_in,
	output logic      [17:0]   db_out,
	output logic               db_oe,
	// serial bus
	input  wire logic          spi_sclk,
	input  wire logic          spi_sdi,
	output logic               spi_sdo,
	// rgb port
	input  wire logic          vsync_in,
	input  wire logic          hsync_in,
	input  wire logic          pixel_clock_in,
	input  wire logic          rgb_enable_in,
	input  wire logic          pixel_valid_flag,
	input  wire logic [17:0]   pixel_data_bus,
	// monitors
	output logic               polarity_out,
	output logic               frame_start_out,
	output logic               line_clock_out,
	output logic               equalize_timing_out,
	output logic               gate_off_out,
	output logic               staging_busy_out,
	// source data
	output logic [6*lhi_pkg::NSRC-1:0] source_data_out
);
	localparam int SW = 51;
	localparam logic [SW-1:0] SRV = 51'h7800000000000;
	logic [SW-1:0] s;
	logic [3:0]  im;
	logic        cs, rs, rw, erd, sck, sdi, vs, hs, pck, en, vld;
	logic [17:0] db, pd;
	logic [6:0]  pv_q;
	lhi_sync #(.W(SW), .RV(SRV)) u_sync (
		.clk (clk),
		.rst_b (rst_b),
		.d ({interface_mode_pins, chip_select_n, register_select_line, rw_wr_n, e_rd_n,
			db_in, spi_sclk, spi_sdi, vsync_in, hsync_in, pixel_clock_in, rgb_enable_in,
			pixel_valid_flag, pixel_data_bus}),
		.q (s)
	);
	assign {im, cs, rs, rw, erd, db, sck, sdi, vs, hs, pck, en, vld, pd} = s;

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pv_q <= 7'h71;
		end else begin
			pv_q <= {erd, rw, sck, vs, hs, pck, cs};
		end
	end

	logic sck_rise, vs_fall, hs_rise, pck_rise;
	assign sck_rise = sck && !pv_q[4];
	assign vs_fall  = !vs && pv_q[3];
	assign hs_rise  = hs && !pv_q[2];
	assign pck_rise = pck && !pv_q[1];

	// control registers
	logic [17:0] index_pointer_q, write_staging_q, read_staging_q; // RULE2
	logic [15:0] entry_q, winh_q, winv_q, ac_q, aset_q;
	logic [17:0] mask_q, cmp_q;
	logic [2:0]  logic_q;
	logic [4:0]  disp_q;
	logic        primed_q;
	logic [8:0]  osc_cnt_q;
	logic [7:0]  dot_q, line_q;
	logic        graphics_memory_pend_q, pix_pend_q;
	lhi_pkg::lhi_ent_t pix_ent_q;

	logic is68, is80, isspi, narrow, run;
	assign is68   = (im[3:2] == lhi_pkg::IM_68); // RULE1
	assign is80   = (im[3:2] == lhi_pkg::IM_80);
	assign isspi  = (im[3:2] == lhi_pkg::IM_SPI);
	assign narrow = im[1];
	assign run    = !disp_q[lhi_pkg::DSP_STBY] && (osc_cnt_q == '0);

	logic [17:0] status;
	assign status = {osc_cnt_q != '0, graphics_memory_pend_q, 8'h00, line_q};

	// parallel cycle ends
	logic pwr_end, prd_end, prd_act;
	logic half_q, rdh_q;
	logic [8:0]  hi_q;
	logic [17:0] pword, rv;
	assign pwr_end = !cs && (is68 ? (!erd && pv_q[6] && !rw) : (is80 && rw && !pv_q[5])); // RULE8
	assign prd_end = !cs && (is68 ? (!erd && pv_q[6] && rw) : (is80 && erd && !pv_q[6]));
	assign prd_act = !cs && (is68 ? (erd && rw) : (is80 && !erd));
	assign rv = rs ? read_staging_q : status; // RULE7

	always_comb begin
		pword = db;
		if (im[1:0] == lhi_pkg::BW_16) begin
			pword = {2'h0, db[15:0]};
		end else if (im[1:0] == lhi_pkg::BW_9) begin
			pword = {hi_q, db[8:0]};
		end else if (narrow) begin
			pword = {2'h0, hi_q[7:0], db[7:0]};
		end
	end

	// serial frame
	lhi_pkg::lhi_spi_t sp_q;
	logic [4:0]  cnt_q;
	logic [17:0] sh_q, so_q;
	logic        srs_q, srw_q;
	always_ff @(posedge clk) begin
		if (!rst_b || !isspi || cs) begin
			sp_q  <= lhi_pkg::SP_IDLE;
			cnt_q <= '0;
			sh_q  <= '0;
			so_q  <= '0;
			srs_q <= 1'b0;
			srw_q <= 1'b0;
		end else begin
			case (sp_q)
				lhi_pkg::SP_IDLE: begin
					sp_q <= lhi_pkg::SP_HEAD;
				end
				lhi_pkg::SP_HEAD: begin
					if (sck_rise) begin
						sh_q  <= {sh_q[16:0], sdi};
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == 5'(lhi_pkg::SPI_HEAD - 1)) begin
							srs_q <= sh_q[0]; // RULE9
							srw_q <= sdi;
							so_q  <= sh_q[0] ? read_staging_q : status;
							cnt_q <= '0;
							sp_q  <= lhi_pkg::SP_DATA;
						end
					end
				end
				default: begin
					if (sck_rise) begin
						sh_q  <= {sh_q[16:0], sdi};
						so_q  <= {so_q[16:0], 1'b0};
						cnt_q <= cnt_q + 1'b1;
						if (cnt_q == 5'(lhi_pkg::DW - 1)) begin
							cnt_q <= '0;
							sp_q  <= lhi_pkg::SP_HEAD;
						end
					end
				end
			endcase
		end
	end

	logic spi_end;
	assign spi_end = (sp_q == lhi_pkg::SP_DATA) && sck_rise && (cnt_q == 5'(lhi_pkg::DW - 1));

	// one transaction carrier for both buses
	lhi_pkg::lhi_tx_t tx;
	always_comb begin
		if (isspi) begin
			tx = '{wr: spi_end && !srw_q, rd: spi_end && srw_q, rs: srs_q,
				data: {sh_q[16:0], sdi}};
		end else begin
			tx = '{wr: pwr_end && (!narrow || half_q),
				rd: prd_end && (!narrow || rdh_q), rs: rs, data: pword};
		end
	end

	always_ff @(posedge clk) begin
		if (!rst_b) begin
			half_q <= 1'b0;
			rdh_q  <= 1'b0;
			hi_q   <= '0;
			db_out <= '0;
			db_oe  <= 1'b0;
		end else begin
			if (pwr_end && narrow) begin
				half_q <= !half_q;
				hi_q   <= db[8:0];
			end
			if (prd_end && narrow) begin
				rdh_q <= !rdh_q;
			end
			db_oe <= prd_act;
			if (!narrow) begin
				db_out <= rv;
			end else if (im[1:0] == lhi_pkg::BW_9) begin
				db_out <= {9'h000, rdh_q ? rv[8:0] : rv[17:9]};
			end else begin
				db_out <= {10'h000, rdh_q ? rv[7:0] : rv[15:8]};
			end
		end
	end

	assign spi_sdo = so_q[17];

	// memory engine
	lhi_pkg::lhi_ent_t fin_d, fout;
	logic fin_v, fin_r, fout_v, dot_en, pop;
	assign fin_v = graphics_memory_pend_q || pix_pend_q;
	assign fin_d = graphics_memory_pend_q ? '{wr: 1'b1, data: write_staging_q} : pix_ent_q; // RULE3
	assign pop   = fout_v && !dot_en; // RULE19
	lhi_fifo #(.W($bits(lhi_pkg::lhi_ent_t)), .DEPTH(lhi_pkg::FIFO_DEPTH)) u_fifo (
		.clk (clk),
		.rst_b (rst_b),
		.in_valid (fin_v),
		.in_ready (fin_r),
		.in_data (fin_d),
		.out_valid (fout_v),
		.out_ready (!dot_en),
		.out_data (fout)
	);

	logic [17:0] graphics_memory_q [lhi_pkg::WORDS]; // RULE18
	logic [14:0] ai;
	logic [17:0] old, opres, fin;
	logic        inwin, cnd, we;
	logic [7:0]  col, row, ncol, nrow;
	assign col   = ac_q[7:0];
	assign row   = ac_q[15:8];
	assign ai    = 15'(row * lhi_pkg::COLS + col);
	assign old   = graphics_memory_q[ai];
	assign inwin = col >= winh_q[7:0] && col <= winh_q[15:8] && row >= winv_q[7:0]
		&& row <= winv_q[15:8] && 32'(ai) < lhi_pkg::WORDS; // RULE17
	assign cnd   = !logic_q[lhi_pkg::LOG_CND] || (fout.data != cmp_q);
	assign fin   = (old & mask_q) | (opres & ~mask_q); // RULE13
	assign we    = pop && fout.wr && inwin && cnd;

	always_comb begin
		case (lhi_pkg::lhi_op_t'(logic_q[1:0]))
			lhi_pkg::OP_OR:  opres = old | fout.data;
			lhi_pkg::OP_AND: opres = old & fout.data;
			lhi_pkg::OP_XOR: opres = old ^ fout.data;
			default:         opres = fout.data;
		endcase
	end

	// one step inside the window, wrapping to the next line
	always_comb begin
		nrow = row;
		if (entry_q[lhi_pkg::ENT_ID]) begin
			ncol = (col == winh_q[15:8]) ? winh_q[7:0] : col + 8'h01; // RULE15
		end else begin
			ncol = (col == winh_q[7:0]) ? winh_q[15:8] : col - 8'h01;
		end
		if (ncol != col + 8'h01 && ncol != col - 8'h01) begin
			if (entry_q[lhi_pkg::ENT_ID + 1]) begin
				nrow = (row == winv_q[15:8]) ? winv_q[7:0] : row + 8'h01;
			end else begin
				nrow = (row == winv_q[7:0]) ? winv_q[15:8] : row - 8'h01;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (we) begin
			graphics_memory_q[ai] <= fin;
		end
	end

	// host registers and address counter
	logic aset_ev;
	assign aset_ev = tx.wr && tx.rs && index_pointer_q[7:0] == lhi_pkg::IX_ADDR;
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			index_pointer_q <= '0; // RULE25
			write_staging_q <= '0;
			read_staging_q  <= '0;
			ac_q     <= '0;
			aset_q   <= '0;
			primed_q <= 1'b0;
			entry_q  <= lhi_pkg::RST_ENTRY;
			winh_q   <= lhi_pkg::RST_WINH;
			winv_q   <= lhi_pkg::RST_WINV;
			mask_q   <= '0;
			cmp_q    <= '0;
			logic_q  <= '0;
			disp_q   <= lhi_pkg::RST_DISP;
			graphics_memory_pend_q <= 1'b0;
		end else begin
			if (fin_r) begin
				graphics_memory_pend_q <= 1'b0;
			end
			if (tx.wr && !tx.rs) begin
				index_pointer_q <= tx.data; // RULE6
			end else if (tx.wr) begin
				write_staging_q <= tx.data;
				if (index_pointer_q[7:0] == lhi_pkg::IX_GRAPHICS_MEMORY) begin
					graphics_memory_pend_q <= 1'b1;
				end else if (index_pointer_q[7:0] == lhi_pkg::IX_ENTRY) begin
					entry_q <= tx.data[15:0];
				end else if (index_pointer_q[7:0] == lhi_pkg::IX_WINH) begin
					winh_q <= tx.data[15:0];
				end else if (index_pointer_q[7:0] == lhi_pkg::IX_WINV) begin
					winv_q <= tx.data[15:0];
				end else if (index_pointer_q[7:0] == lhi_pkg::IX_MASK) begin
					mask_q <= tx.data;
				end else if (index_pointer_q[7:0] == lhi_pkg::IX_LOGIC) begin
					logic_q <= tx.data[2:0];
				end else if (index_pointer_q[7:0] == lhi_pkg::IX_CMP) begin
					cmp_q <= tx.data;
				end else if (index_pointer_q[7:0] == lhi_pkg::IX_DISP) begin
					disp_q <= tx.data[4:0];
				end else if (index_pointer_q[7:0] == lhi_pkg::IX_ADDR) begin
					aset_q <= tx.data[15:0];
				end
			end
			if (aset_ev) begin
				ac_q     <= tx.data[15:0]; // RULE14
				primed_q <= 1'b0;
			end else if (vs_fall && disp_q[lhi_pkg::DSP_RGB]) begin
				ac_q <= aset_q;
			end else if (pop) begin
				ac_q <= {nrow, ncol}; // RULE10
			end
			if (tx.rd && tx.rs) begin
				read_staging_q <= old; // RULE4
				primed_q       <= 1'b1;
			end else if (pop && logic_q[1:0] != 2'h0) begin
				read_staging_q <= old; // RULE5
			end
		end
	end

	// rgb pixel capture
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			pix_pend_q <= 1'b0;
			pix_ent_q  <= '0;
		end else begin
			if (fin_r && !graphics_memory_pend_q) begin
				pix_pend_q <= 1'b0;
			end
			if (pck_rise && en && !cs && disp_q[lhi_pkg::DSP_RGB]) begin
				pix_pend_q <= 1'b1; // RULE11
				pix_ent_q  <= '{wr: !vld, data: pd}; // RULE10
			end
		end
	end

	// oscillator start and timing generator
	logic [1:0] div_q;
	logic       pol_q;
	logic [17:0] lbuf_q [lhi_pkg::COLS];
	logic [14:0] ri;
	assign dot_en = run && div_q == '0;
	assign ri     = 15'(line_q * lhi_pkg::COLS + dot_q);
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			osc_cnt_q <= '0;
			div_q     <= '0;
			dot_q     <= '0;
			line_q    <= '0;
			pol_q     <= 1'b0;
		end else begin
			if (disp_q[lhi_pkg::DSP_STBY]) begin
				osc_cnt_q <= 9'(lhi_pkg::OSC_START_CLKS); // RULE21
			end else if (osc_cnt_q != '0) begin
				osc_cnt_q <= osc_cnt_q - 1'b1;
			end
			if (run) begin
				div_q <= (div_q == 2'(lhi_pkg::DOT_DIV - 1)) ? 2'h0 : div_q + 2'h1;
			end
			if (vs_fall && (disp_q[lhi_pkg::DSP_RGB] || disp_q[lhi_pkg::DSP_VSY])) begin
				dot_q  <= '0; // RULE12
				line_q <= '0;
				pol_q  <= !pol_q;
			end else if (hs_rise && disp_q[lhi_pkg::DSP_RGB]) begin
				dot_q  <= '0;
				line_q <= line_q + 8'h01;
			end else if (dot_en) begin
				dot_q <= dot_q + 8'h01;
				if (dot_q == 8'(lhi_pkg::LINE_DOTS - 1)) begin
					dot_q  <= '0;
					line_q <= line_q + 8'h01;
					if (line_q == 8'(lhi_pkg::FRAME_LINES - 1)) begin
						line_q <= '0;
						pol_q  <= !pol_q;
					end
				end
			end
		end
	end

	always_ff @(posedge clk) begin
		if (dot_en && dot_q < 8'(lhi_pkg::COLS) && line_q < 8'(lhi_pkg::ROWS)) begin
			lbuf_q[dot_q] <= graphics_memory_q[ri]; // RULE19
		end
	end

	// source order, reversed by the shift bit
	logic [6*lhi_pkg::NSRC-1:0] lv, sv;
	for (genvar c = 0; c < lhi_pkg::NSRC; c++) begin : g_src
		assign lv[c*6 +: 6] = lbuf_q[c/3][17-6*(c%3) -: 6];
		assign sv[c*6 +: 6] = disp_q[lhi_pkg::DSP_SS] ?
			lv[(lhi_pkg::NSRC-1-c)*6 +: 6] : lv[c*6 +: 6]; // RULE23
	end

	logic latch_ev;
	assign latch_ev = dot_en && dot_q == 8'(lhi_pkg::COLS) && line_q < 8'(lhi_pkg::ROWS);
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			source_data_out     <= '0;
			polarity_out        <= 1'b0;
			frame_start_out     <= 1'b0;
			line_clock_out      <= 1'b0;
			equalize_timing_out <= 1'b0;
			gate_off_out        <= 1'b0;
			staging_busy_out    <= 1'b0;
		end else begin
			if (latch_ev) begin
				source_data_out <= sv; // RULE22
			end
			polarity_out        <= pol_q; // RULE20
			frame_start_out     <= run && line_q == '0;
			line_clock_out      <= run && dot_q < 8'(lhi_pkg::LCLK_DOTS);
			equalize_timing_out <= run && dot_q < 8'(lhi_pkg::EQ_DOTS); // RULE24
			gate_off_out        <= run && disp_q[lhi_pkg::DSP_ON] && line_q < 8'(lhi_pkg::ROWS);
			staging_busy_out    <= graphics_memory_pend_q;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	property p_aset; aset_ev |=> ac_q == $past(tx.data[15:0]) && !primed_q; endproperty
	a_aset: assert property (p_aset) else $error("address set not loaded"); // RULE14
	property p_rdhold; tx.rd && !pop && !aset_ev && !vs_fall |=> $stable(ac_q); endproperty
	a_rdhold: assert property (p_rdhold) else $error("read moved counter"); // RULE16
	property p_slot; pop |-> !dot_en; endproperty
	a_slot: assert property (p_slot) else $error("host access in refresh slot"); // RULE19
	property p_step; pop && !aset_ev && !vs_fall && entry_q[5:4] == 2'h3 && col < winh_q[15:8]
		|=> ac_q[7:0] == $past(col) + 8'h01; endproperty
	a_step: assert property (p_step) else $error("counter did not step"); // RULE15
	property p_cs; pck_rise && cs |=> $stable(pix_ent_q); endproperty
	a_cs: assert property (p_cs) else $error("pixel taken while deselected"); // RULE10
	property p_stby; disp_q[lhi_pkg::DSP_STBY] ##1 disp_q[lhi_pkg::DSP_STBY] && !vs_fall
		&& !hs_rise |-> $stable(line_q) && $stable(dot_q); endproperty
	a_stby: assert property (p_stby) else $error("timing ran in standby"); // RULE21
	property p_win; we |-> inwin; endproperty
	a_win: assert property (p_win) else $error("write outside window"); // RULE17
	property p_ss; latch_ev && !disp_q[lhi_pkg::DSP_SS]
		|=> source_data_out[5:0] == $past(lbuf_q[0][17:12]); endproperty
	a_ss: assert property (p_ss) else $error("source order wrong"); // RULE23
	property p_stage; tx.wr && tx.rs && index_pointer_q[7:0] == lhi_pkg::IX_GRAPHICS_MEMORY
		|=> graphics_memory_pend_q ##1 staging_busy_out; endproperty
	a_stage: assert property (p_stage) else $error("write not staged"); // RULE3
endmodule : lhi_host_port

/* lhi_host_model.sv */
/*
 lhi_host_model: host processor on the 80-style parallel bus, 18 bits wide.
 assumes: the port is strapped for 80-style 18-bit mode; pins change at the falling edge.
*/
module lhi_host_model (
	// clock
	input  wire logic        clk,
	// parallel bus
	output logic             chip_select_n,
	output logic             register_select_line,
	output logic             rw_wr_n,
	output logic             e_rd_n,
	output logic [17:0]      db_in,
	input  wire logic [17:0] db_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		chip_select_n = 1'b1;
		register_select_line = 1'b0;
		rw_wr_n = 1'b1;
		e_rd_n = 1'b1;
		db_in = 18'h00000;
	end
	// write: taken at the rising write strobe, phases well above four cycles
	task automatic bus_write(input logic rs, input logic [17:0] d);
		@(negedge clk);
		chip_select_n = 1'b0;
		register_select_line = rs;
		db_in = d;
		rw_wr_n = 1'b0;
		repeat (10) @(negedge clk);
		rw_wr_n = 1'b1;
		repeat (10) @(negedge clk);
		chip_select_n = 1'b1;
		db_in = ~d;
	endtask : bus_write
	// read: data taken at a rising edge while the read strobe is still low
	task automatic bus_read(input logic rs, output logic [17:0] d);
		@(negedge clk);
		chip_select_n = 1'b0;
		register_select_line = rs;
		e_rd_n = 1'b0;
		repeat (10) @(posedge clk);
		d = db_out;
		@(negedge clk);
		e_rd_n = 1'b1;
		repeat (10) @(negedge clk);
		chip_select_n = 1'b1;
	endtask : bus_read
endmodule : lhi_host_model

/* lcd_host_interface_graphics_memory_access_tb_top.sv */
/*
 lcd_host_interface_graphics_memory_access_tb_top: self-checking bench for lhi_host_port.
 assumes: lhi_pkg and lhi_host_model are compiled first; rgb and serial pins stay idle.
*/
module lcd_host_interface_graphics_memory_access_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic lo = 1'b0;
	logic hi = 1'b1;
	logic [17:0] pix = 18'h00000;
	logic [3:0] im = {lhi_pkg::IM_80, lhi_pkg::BW_18};
	logic cs_n, rs, wr_n, rd_n, db_oe, sdo, pol, fs, lc, eq, go, busy;
	logic [17:0] db_in, db_out, d;
	logic [6*lhi_pkg::NSRC-1:0] src;
	int num_errors = 0;
	int comparisons = 0;
	int cycles = 0;
	always #20 clk = ~clk;
	lhi_host_model host (.clk(clk), .chip_select_n(cs_n), .register_select_line(rs),
		.rw_wr_n(wr_n), .e_rd_n(rd_n), .db_in(db_in), .db_out(db_out));
	lhi_host_port dut (.clk(clk), .rst_b(rst_b), .interface_mode_pins(im),
		.chip_select_n(cs_n), .register_select_line(rs), .rw_wr_n(wr_n), .e_rd_n(rd_n),
		.db_in(db_in), .db_out(db_out), .db_oe(db_oe), .spi_sclk(lo), .spi_sdi(lo),
		.spi_sdo(sdo), .vsync_in(hi), .hsync_in(lo), .pixel_clock_in(lo),
		.rgb_enable_in(lo), .pixel_valid_flag(hi), .pixel_data_bus(pix),
		.polarity_out(pol), .frame_start_out(fs), .line_clock_out(lc),
		.equalize_timing_out(eq), .gate_off_out(go), .staging_busy_out(busy),
		.source_data_out(src));
	task automatic wrap_up;
		if (num_errors == 0 && comparisons > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : wrap_up
	task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : check
	// address set, then point the index at memory data
	task automatic set_addr(input logic [17:0] a);
		host.bus_write(1'b0, {10'h000, lhi_pkg::IX_ADDR});
		host.bus_write(1'b1, a);
		host.bus_write(1'b0, {10'h000, lhi_pkg::IX_GRAPHICS_MEMORY});
	endtask : set_addr
	task automatic t_reset;
		check("read enable", 18'h00000, {17'h00000, db_oe});
		check("source data", 18'h00000, {17'h00000, |src});
	endtask : t_reset
	task automatic t_status;
		host.bus_read(1'b0, d);
		check("status upper", 18'h00000, {d[17:8], 8'h00});
		check("serial out idle", 18'h00000, {17'h00000, sdo});
		check("read enable idle", 18'h00000, {17'h00000, db_oe});
	endtask : t_status
	task automatic t_graphics_memory;
		set_addr(18'h00000);
		host.bus_write(1'b1, 18'h2A5A5);
		host.bus_write(1'b1, 18'h15A5A);
		repeat (30) @(negedge clk);
		set_addr(18'h00000);
		host.bus_read(1'b1, d);
		host.bus_read(1'b1, d);
		check("first word", 18'h2A5A5, d);
		host.bus_read(1'b1, d);
		check("reread word", 18'h2A5A5, d);
		set_addr(18'h00001);
		host.bus_read(1'b1, d);
		host.bus_read(1'b1, d);
		check("second word", 18'h15A5A, d);
		check("staging idle", 18'h00000, {17'h00000, busy});
	endtask : t_graphics_memory
	task automatic t_mask;
		host.bus_write(1'b0, {10'h000, lhi_pkg::IX_MASK});
		host.bus_write(1'b1, 18'h3FF00);
		set_addr(18'h00000);
		host.bus_write(1'b1, 18'h00000);
		repeat (30) @(negedge clk);
		host.bus_write(1'b0, {10'h000, lhi_pkg::IX_MASK});
		host.bus_write(1'b1, 18'h00000);
		set_addr(18'h00000);
		host.bus_read(1'b1, d);
		host.bus_read(1'b1, d);
		check("masked word", 18'h2A500, d);
	endtask : t_mask
	task automatic t_timing;
		int nl;
		int ne;
		nl = 0;
		ne = 0;
		@(posedge clk);
		while (lc !== 1'b0) @(posedge clk);
		while (lc !== 1'b1) @(posedge clk);
		repeat (40) begin
			nl += int'(lc === 1'b1);
			ne += int'(eq === 1'b1);
			@(posedge clk);
		end
		check("line clock width", 18'(lhi_pkg::LCLK_DOTS * lhi_pkg::DOT_DIV), 18'(nl));
		check("equalize width", 18'(lhi_pkg::EQ_DOTS * lhi_pkg::DOT_DIV), 18'(ne));
	endtask : t_timing
	// a hang counts as a mismatch
	always @(posedge clk) begin
		cycles++;
		if (cycles == 30000) begin
			num_errors++;
			wrap_up();
		end
	end
	initial begin
		repeat (12) @(negedge clk);
		t_reset();
		rst_b = 1'b1;
		repeat (4) @(negedge clk);
		t_status();
		t_graphics_memory();
		t_mask();
		t_timing();
		wrap_up();
	end
endmodule : lcd_host_interface_graphics_memory_access_tb_top
